/* File: rtc_pkg.sv */
// rtc_pkg: register map, field layout, reset values and timing for the bcd calendar rtc
// assumes a 100 MHz system clock; the 32 kHz tick is generated internally from it
package rtc_pkg;
   localparam int unsigned clock_hz = 100_000_000;
   localparam int unsigned tick_hz = 32_768;
   localparam int unsigned tick_div = clock_hz / tick_hz;
   localparam logic [15:0] ticks_per_second = 16'h8000;

   localparam logic [7:0] seconds_offset = 8'h00;
   localparam logic [7:0] minutes_offset = 8'h04;
   localparam logic [7:0] hours_offset = 8'h08;
   localparam logic [7:0] days_offset = 8'h0C;
   localparam logic [7:0] months_offset = 8'h10;
   localparam logic [7:0] years_offset = 8'h14;
   localparam logic [7:0] weeks_offset = 8'h18;
   localparam logic [7:0] alarm_seconds_offset = 8'h20;
   localparam logic [7:0] alarm_minutes_offset = 8'h24;
   localparam logic [7:0] alarm_hours_offset = 8'h28;
   localparam logic [7:0] alarm_days_offset = 8'h2C;
   localparam logic [7:0] alarm_months_offset = 8'h30;
   localparam logic [7:0] alarm_years_offset = 8'h34;
   localparam logic [7:0] control_offset = 8'h40;
   localparam logic [7:0] status_offset = 8'h44;
   localparam logic [7:0] interrupts_offset = 8'h48;
   localparam logic [7:0] comp_lsb_offset = 8'h4C;
   localparam logic [7:0] comp_msb_offset = 8'h50;

   // control fields
   localparam int ctrl_run_bit = 0;
   localparam int ctrl_round_bit = 1;
   localparam int ctrl_auto_comp_bit = 2;
   localparam int ctrl_twelve_hour_bit = 3;
   localparam int ctrl_snapshot_bit = 6;
   // status fields
   localparam int stat_running_bit = 1;
   localparam int stat_second_bit = 2;
   localparam int stat_minute_bit = 3;
   localparam int stat_hour_bit = 4;
   localparam int stat_day_bit = 5;
   localparam int stat_alarm_bit = 6;
   localparam int stat_period_bit = 7;
   // interrupt fields
   localparam int irq_period_lsb = 0;
   localparam int irq_periodic_enable_bit = 2;
   localparam int irq_alarm_enable_bit = 3;

   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [7:0] pm_flag = 8'h80;

   typedef enum logic [1:0] {
      period_second = 2'b00,
      period_minute = 2'b01,
      period_hour = 2'b10,
      period_day = 2'b11
   } period_select_type;

   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] days;
      logic [7:0] months;
      logic [7:0] years;
      logic [7:0] weeks;
   } time_calendar_type;

   localparam time_calendar_type calendar_reset = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};

   typedef struct packed {
      logic second;
      logic minute;
      logic hour;
      logic day;
   } carry_type;
endpackage

/* File: bcd_digit_pair.sv */
// bcd_digit_pair: increments a two-digit bcd value with wrap to a low bound
// assumes the input already holds legal bcd
`timescale 1ns/1ps
module bcd_digit_pair
   import rtc_pkg::*;
(
   input wire logic [7:0] value,
   input wire logic [7:0] top,
   input wire logic [7:0] low,
   output logic [7:0] next_value,
   output logic wrap
);
   always_comb
   begin
      wrap = (value >= top);
      if (wrap)
      begin
         next_value = low;
      end
      else if (value[3:0] == 4'h9)
      begin
         next_value = {value[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         next_value = {value[7:4], value[3:0] + 4'h1};
      end
   end
endmodule

/* File: bcd_calendar_rtc.sv */
// bcd_calendar_rtc: bcd time and calendar with alarm, periodic event, rounding, snapshot, drift compensation
// assumes an apb master on the system clock; registers one per aligned word, data in the low byte
`timescale 1ns/1ps
module bcd_calendar_rtc
   import rtc_pkg::*;
#(
   parameter int unsigned tick_divide = tick_div
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic periodic_irq_n,
   output logic alarm_irq_n,
   output logic wake_request
);
   time_calendar_type live;
   time_calendar_type shadow;
   time_calendar_type next_live;
   time_calendar_type next_shadow;
   time_calendar_type alarm;
   time_calendar_type next_alarm;
   logic [7:0] control;
   logic [7:0] next_control;
   logic [7:0] irq_control;
   logic [7:0] next_irq_control;
   logic [15:0] compensation;
   logic [15:0] next_compensation;
   logic [15:0] sub_count;
   logic [15:0] next_sub_count;
   logic [15:0] divider;
   logic [15:0] next_divider;
   logic [3:0] event_flags;
   logic [3:0] next_event_flags;
   logic alarm_flag;
   logic next_alarm_flag;
   logic period_flag;
   logic next_period_flag;
   logic snapshot_valid;
   logic next_snapshot_valid;
   logic period_pulse_n;
   logic next_period_pulse_n;
   logic [31:0] next_prdata;

   logic access;
   logic wr;
   logic rd;
   logic tick32;
   logic second_tick;
   logic running;
   logic twelve_hour;
   logic leap;
   logic [7:0] month_days;
   logic [7:0] inc_sec;
   logic [7:0] inc_min;
   logic [7:0] inc_hour;
   logic [7:0] inc_day;
   logic [7:0] inc_month;
   logic [7:0] inc_year;
   logic [7:0] inc_week;
   logic wrap_sec;
   logic wrap_min;
   logic wrap_hour;
   logic wrap_day;
   logic wrap_month;
   logic unused_wrap_year;
   logic unused_wrap_week;
   logic [7:0] hours_view;
   logic [7:0] hours_written;
   carry_type carry;
   logic period_hit;
   logic alarm_match;
   logic mapped;
   logic [31:0] read_word;

   assign access = psel && penable;
   assign wr = access && pwrite;
   // read data is captured in the setup phase so that it stands at the access edge
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign running = control[ctrl_run_bit];
   assign twelve_hour = control[ctrl_twelve_hour_bit];
   assign tick32 = (divider == 16'(tick_divide - 1));
   // one-second point: prescaler reaches its top while running
   // equality, so a negative compensation wraps through zero and lengthens the second
   assign second_tick = tick32 && running && (sub_count == ticks_per_second - 16'h0001);
   assign leap = (live.years[4] == 1'b0) ? (live.years[1:0] == 2'b00) : (live.years[1:0] == 2'b10);

   // live hours are kept in 24-hour form; format converted at the bus only
   function automatic logic [7:0] to_twelve(input logic [7:0] h);
      logic [7:0] t;
      t = h;
      if (h == 8'h00)
      begin
         t = 8'h12;
      end
      else if (h >= 8'h13)
      begin
         t = (h[3:0] >= 4'h2) ? {h[7:4] - 4'h1, h[3:0] - 4'h2} : {h[7:4] - 4'h2, h[3:0] + 4'h8};
         t = t | pm_flag;
      end
      else if (h == 8'h12)
      begin
         t = 8'h12 | pm_flag;
      end
      return t;
   endfunction

   function automatic logic [7:0] from_twelve(input logic [7:0] h);
      logic [7:0] b;
      logic [7:0] r;
      b = {1'b0, h[6:0]};
      r = b;
      if (b == 8'h12)
      begin
         r = h[7] ? 8'h12 : 8'h00;
      end
      else if (h[7])
      begin
         r = (b[3:0] >= 4'h8) ? {b[7:4] + 4'h2, b[3:0] - 4'h8} : {b[7:4] + 4'h1, b[3:0] + 4'h2};
      end
      return r;
   endfunction

   assign hours_view = twelve_hour ? to_twelve(snapshot_valid ? shadow.hours : live.hours)
                                   : (snapshot_valid ? shadow.hours : live.hours);
   assign hours_written = twelve_hour ? from_twelve(pwdata[7:0]) : pwdata[7:0];

   always_comb
   begin
      unique case (live.months)
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         8'h02: month_days = leap ? 8'h29 : 8'h28;
         default: month_days = 8'h31;
      endcase
   end

   bcd_digit_pair sec_pair (.value(live.seconds), .top(8'h59), .low(8'h00), .next_value(inc_sec), .wrap(wrap_sec));
   bcd_digit_pair min_pair (.value(live.minutes), .top(8'h59), .low(8'h00), .next_value(inc_min), .wrap(wrap_min));
   bcd_digit_pair hour_pair (.value(live.hours), .top(8'h23), .low(8'h00), .next_value(inc_hour), .wrap(wrap_hour));
   bcd_digit_pair day_pair (.value(live.days), .top(month_days), .low(8'h01), .next_value(inc_day), .wrap(wrap_day));
   bcd_digit_pair month_pair (.value(live.months), .top(8'h12), .low(8'h01), .next_value(inc_month),
                              .wrap(wrap_month));
   bcd_digit_pair year_pair (.value(live.years), .top(8'h99), .low(8'h00), .next_value(inc_year),
                             .wrap(unused_wrap_year));
   bcd_digit_pair week_pair (.value(live.weeks), .top(8'h06), .low(8'h00), .next_value(inc_week),
                             .wrap(unused_wrap_week));

   assign carry.second = second_tick;
   assign carry.minute = second_tick && wrap_sec;
   assign carry.hour = carry.minute && wrap_min;
   assign carry.day = carry.hour && wrap_hour;

   always_comb
   begin
      unique case (period_select_type'(irq_control[irq_period_lsb +: 2]))
         period_second: period_hit = carry.second;
         period_minute: period_hit = carry.minute;
         period_hour: period_hit = carry.hour;
         period_day: period_hit = carry.day;
      endcase
   end

   // compared against the time that the tick is about to show
   assign alarm_match = (next_live.seconds == alarm.seconds) && (next_live.minutes == alarm.minutes)
                        && (next_live.hours == alarm.hours) && (next_live.days == alarm.days)
                        && (next_live.months == alarm.months) && (next_live.years == alarm.years);

   // counting and register writes
   always_comb
   begin
      next_live = live;
      next_alarm = alarm;
      next_control = control;
      next_irq_control = irq_control;
      next_compensation = compensation;
      next_shadow = shadow;
      next_snapshot_valid = snapshot_valid;
      next_divider = tick32 ? 16'h0000 : divider + 16'h0001;
      next_sub_count = sub_count;
      if (tick32 && running)
      begin
         if (second_tick)
         begin
            // the first second of each hour is shortened or stretched by the compensation
            if (control[ctrl_auto_comp_bit] && carry.hour)
            begin
               next_sub_count = compensation;
            end
            else
            begin
               next_sub_count = 16'h0000;
            end
         end
         else
         begin
            next_sub_count = sub_count + 16'h0001;
         end
      end
      if (second_tick)
      begin
         if (control[ctrl_round_bit])
         begin
            // round: 30 s or more goes up a full minute
            next_control[ctrl_round_bit] = 1'b0;
            next_live.seconds = 8'h00;
            if (live.seconds >= 8'h30)
            begin
               next_live.minutes = inc_min;
               if (wrap_min)
               begin
                  next_live.hours = inc_hour;
               end
            end
         end
         else
         begin
            next_live.seconds = inc_sec;
            if (carry.minute)
            begin
               next_live.minutes = inc_min;
            end
            if (carry.hour)
            begin
               next_live.hours = inc_hour;
            end
            if (carry.day)
            begin
               next_live.days = inc_day;
               next_live.weeks = inc_week;
               if (wrap_day)
               begin
                  next_live.months = inc_month;
                  if (wrap_month)
                  begin
                     next_live.years = inc_year;
                  end
               end
            end
         end
      end
      if (control[ctrl_snapshot_bit])
      begin
         next_shadow = live;
         next_snapshot_valid = 1'b1;
         next_control[ctrl_snapshot_bit] = 1'b0;
      end
      if (wr)
      begin
         unique case (paddr)
            seconds_offset: next_live.seconds = pwdata[7:0];
            minutes_offset: next_live.minutes = pwdata[7:0];
            hours_offset: next_live.hours = hours_written;
            days_offset: next_live.days = pwdata[7:0];
            months_offset: next_live.months = pwdata[7:0];
            years_offset: next_live.years = pwdata[7:0];
            weeks_offset: next_live.weeks = pwdata[7:0];
            alarm_seconds_offset: next_alarm.seconds = pwdata[7:0];
            alarm_minutes_offset: next_alarm.minutes = pwdata[7:0];
            alarm_hours_offset: next_alarm.hours = hours_written;
            alarm_days_offset: next_alarm.days = pwdata[7:0];
            alarm_months_offset: next_alarm.months = pwdata[7:0];
            alarm_years_offset: next_alarm.years = pwdata[7:0];
            control_offset: next_control = pwdata[7:0];
            interrupts_offset: next_irq_control = pwdata[7:0];
            comp_lsb_offset: next_compensation[7:0] = pwdata[7:0];
            comp_msb_offset: next_compensation[15:8] = pwdata[7:0];
            default: ;
         endcase
         // a new live write ends the frozen view
         if (paddr <= weeks_offset)
         begin
            next_snapshot_valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         live <= calendar_reset;
         shadow <= calendar_reset;
         alarm <= calendar_reset;
         control <= control_reset;
         irq_control <= 8'h00;
         compensation <= 16'h0000;
         sub_count <= 16'h0000;
         divider <= 16'h0000;
         snapshot_valid <= 1'b0;
      end
      else
      begin
         live <= next_live;
         shadow <= next_shadow;
         alarm <= next_alarm;
         control <= next_control;
         irq_control <= next_irq_control;
         compensation <= next_compensation;
         sub_count <= next_sub_count;
         divider <= next_divider;
         snapshot_valid <= next_snapshot_valid;
      end
   end

   // event and interrupt state; set wins over a write-one clear
   always_comb
   begin
      next_event_flags = event_flags;
      next_alarm_flag = alarm_flag;
      next_period_flag = period_flag;
      next_period_pulse_n = 1'b1;
      if (wr && paddr == status_offset)
      begin
         if (pwdata[stat_alarm_bit])
         begin
            next_alarm_flag = 1'b0;
         end
         if (pwdata[stat_period_bit])
         begin
            next_period_flag = 1'b0;
         end
      end
      if (period_hit && irq_control[irq_periodic_enable_bit])
      begin
         next_event_flags = {carry.day, carry.hour, carry.minute, carry.second};
         next_period_flag = 1'b1;
         next_period_pulse_n = 1'b0;
      end
      if (second_tick && alarm_match && irq_control[irq_alarm_enable_bit])
      begin
         next_alarm_flag = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         event_flags <= 4'h0;
         alarm_flag <= 1'b0;
         period_flag <= 1'b0;
         period_pulse_n <= 1'b1;
      end
      else
      begin
         event_flags <= next_event_flags;
         alarm_flag <= next_alarm_flag;
         period_flag <= next_period_flag;
         period_pulse_n <= next_period_pulse_n;
      end
   end

   assign periodic_irq_n = period_pulse_n;
   assign alarm_irq_n = !alarm_flag;
   assign wake_request = alarm_flag;

   // read mux: shadow copy while a snapshot is held
   always_comb
   begin
      time_calendar_type view;
      view = snapshot_valid ? shadow : live;
      mapped = 1'b1;
      read_word = 32'h0000_0000;
      unique case (paddr)
         seconds_offset: read_word[7:0] = view.seconds;
         minutes_offset: read_word[7:0] = view.minutes;
         hours_offset: read_word[7:0] = hours_view;
         days_offset: read_word[7:0] = view.days;
         months_offset: read_word[7:0] = view.months;
         years_offset: read_word[7:0] = view.years;
         weeks_offset: read_word[7:0] = view.weeks;
         alarm_seconds_offset: read_word[7:0] = alarm.seconds;
         alarm_minutes_offset: read_word[7:0] = alarm.minutes;
         alarm_hours_offset: read_word[7:0] = twelve_hour ? to_twelve(alarm.hours) : alarm.hours;
         alarm_days_offset: read_word[7:0] = alarm.days;
         alarm_months_offset: read_word[7:0] = alarm.months;
         alarm_years_offset: read_word[7:0] = alarm.years;
         control_offset: read_word[7:0] = control;
         status_offset: read_word[7:0] = {period_flag, alarm_flag, event_flags, running, 1'b0};
         interrupts_offset: read_word[7:0] = irq_control;
         comp_lsb_offset: read_word[7:0] = compensation[7:0];
         comp_msb_offset: read_word[7:0] = compensation[15:8];
         default: mapped = 1'b0;
      endcase
      next_prdata = rd ? read_word : prdata;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         prdata <= 32'h0000_0000;
      end
      else
      begin
         prdata <= next_prdata;
      end
   end

   assign pslverr = access && !mapped;
endmodule

/* File: rtc_checker.sv */
// rtc_checker: port-level properties of the bcd calendar rtc
// assumes it is bound into bcd_calendar_rtc and sees only its ports
`timescale 1ns/1ps
module rtc_checker
   import rtc_pkg::*;
#(
   parameter int unsigned tick_divide = tick_div
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic periodic_irq_n,
   input wire logic alarm_irq_n,
   input wire logic wake_request
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic acc;
   assign acc = psel && penable;
   sequence s_pulse;
      $fell(periodic_irq_n);
   endsequence
   sequence s_quiet;
      periodic_irq_n [*8];
   endsequence
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not answered at once");
   property p_unmapped; acc && !pwrite && paddr == 8'h1C |-> pslverr && prdata == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_mapped; acc && paddr == seconds_offset |-> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_err_phase; pslverr |-> acc; endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
   property p_pulse; s_pulse |=> s_quiet; endproperty
   a_pulse: assert property (p_pulse) else $error("periodic event not a single edge");
   property p_wake; wake_request == !alarm_irq_n; endproperty
   a_wake: assert property (p_wake) else $error("wake request differs from alarm");
   property p_alarm_hold;
      !alarm_irq_n && !(acc && pwrite && paddr == status_offset) |=> !alarm_irq_n;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm level dropped without clear");
   property p_reset_idle; $fell(sys_rst) |-> periodic_irq_n && alarm_irq_n && !wake_request; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("interrupt active after reset");
   property p_bcd;
      acc && !pwrite && paddr == seconds_offset |-> prdata[3:0] < 4'hA && prdata[7:4] < 4'h6;
   endproperty
   a_bcd: assert property (p_bcd) else $error("seconds not legal bcd");
endmodule
bind bcd_calendar_rtc rtc_checker #(.tick_divide(tick_divide)) i_checker (.clock(clock), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .periodic_irq_n(periodic_irq_n), .alarm_irq_n(alarm_irq_n),
   .wake_request(wake_request));

/* File: testbench.sv */
// testbench: self-checking apb bench for the bcd calendar rtc
// assumes tick_divide of 1, so one second lasts 32768 clocks; prdata is taken at the access edge
`timescale 1ns/1ps
module testbench
   import rtc_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, periodic_irq_n, alarm_irq_n, wake_request;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int num_checks = 0;
   int waited;
   int lim [6] = '{60, 60, 24, 28, 12, 100};
   bcd_calendar_rtc #(.tick_divide(1)) i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .periodic_irq_n(periodic_irq_n), .alarm_irq_n(alarm_irq_n), .wake_request(wake_request));
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic [7:0] bcd(input int v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction
   // entered just after a rising edge; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
      begin
         @(posedge clock);
      end
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask
   task automatic load(input logic [7:0] base, input logic [7:0] v [7], input int cnt);
      for (int i = 0; i < cnt; i++)
         apb(1'b1, base + 8'(i * 4), {24'h00_0000, v[i]});
   endtask
   task automatic cmp_cal(input logic [7:0] v [7], input int cnt);
      for (int i = 0; i < cnt; i++)
         rchk("calendar", 8'(i * 4), {24'h00_0000, v[i]});
   endtask
   task automatic wait_tick();
      int n;
      n = 0;
      while (periodic_irq_n !== 1'b0 && n < 40000)
      begin
         @(posedge clock);
         n++;
      end
      waited = n;
      check("tick", {31'h0, periodic_irq_n}, 32'h0000_0000);
      @(posedge clock);
      check("tick width", {31'h0, periodic_irq_n}, 32'h0000_0001);
   endtask
   initial
   begin
      repeat (75000) @(posedge clock);
      error_cnt++;
      results();
   end
   initial
   begin
      int k;
      logic [7:0] v;
      void'($urandom(32'hc216));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++)
         rchk("reset value", 8'(i * 4), {24'h00_0000, calendar_reset[55 - 8 * i -: 8]});
      rchk("control reset", control_offset, 32'h0000_0000);
      rchk("unmapped read", 8'h1C, 32'h0000_0000);
      check("unmapped error", {31'h0, err}, 32'h0000_0001);
      // random alarm fields, each inside its legal range
      for (int r = 0; r < 12; r++)
      begin
         k = $urandom % 6;
         v = bcd(int'($urandom % lim[k]) + int'(k == 3 || k == 4));
         apb(1'b1, alarm_seconds_offset + 8'(k * 4), {24'h00_0000, v});
         rchk("alarm readback", alarm_seconds_offset + 8'(k * 4), {24'h00_0000, v});
      end
      // february end in a common year, alarm on the following instant
      apb(1'b1, interrupts_offset, 32'h0000_000C);
      load(seconds_offset, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h03, 8'h06}, 7);
      load(alarm_seconds_offset, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h03, 8'h00}, 6);
      apb(1'b1, control_offset, 32'h0000_0001);
      apb(1'b0, status_offset, 32'h0000_0000);
      check("running", {31'h0, rd[stat_running_bit]}, 32'h0000_0001);
      wait_tick();
      cmp_cal('{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h03, 8'h00}, 7);
      check("alarm", {31'h0, alarm_irq_n}, 32'h0000_0000);
      check("wake", {31'h0, wake_request}, 32'h0000_0001);
      apb(1'b0, status_offset, 32'h0000_0000);
      check("event flags", {26'h0, rd[7:2]}, 32'h0000_003F);
      apb(1'b1, status_offset, 32'h0000_00C0);
      check("alarm cleared", {31'h0, alarm_irq_n}, 32'h0000_0001);
      // leap february, loaded while running
      load(seconds_offset, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h04, 8'h03}, 7);
      rchk("hours written", hours_offset, 32'h0000_0023);
      // compensation loaded before the hourly point shortens the next second to 4096 clocks
      apb(1'b1, comp_lsb_offset, 32'h0000_0000);
      apb(1'b1, comp_msb_offset, 32'h0000_0070);
      apb(1'b1, control_offset, 32'h0000_0005);
      wait_tick();
      rchk("leap day", days_offset, 32'h0000_0029);
      rchk("leap month", months_offset, 32'h0000_0002);
      apb(1'b1, control_offset, 32'h0000_0009);
      rchk("twelve hour", hours_offset, 32'h0000_0012);
      // rounding up from 45 seconds crosses the hour
      apb(1'b1, control_offset, 32'h0000_0001);
      load(seconds_offset, '{8'h45, 8'h59, 8'h10, 8'h01, 8'h01, 8'h01, 8'h01}, 3);
      apb(1'b1, control_offset, 32'h0000_0003);
      wait_tick();
      check("compensated second", {31'h0, waited > 4000 && waited < 4096}, 32'h0000_0001);
      cmp_cal('{8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
      rchk("round cleared", control_offset, 32'h0000_0001);
      apb(1'b1, control_offset, 32'h0000_0041);
      rchk("snapshot cleared", control_offset, 32'h0000_0001);
      rchk("shadow seconds", seconds_offset, 32'h0000_0000);
      apb(1'b1, control_offset, 32'h0000_0000);
      apb(1'b0, status_offset, 32'h0000_0000);
      check("stopped", {31'h0, rd[stat_running_bit]}, 32'h0000_0000);
      results();
   end
endmodule
